/* File: hw/acc_ctrl_top.sv */
// Register bank and control logic around the analog comparator core
`include "acc_regs.svh"

module acc_ctrl_top (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       wb_cyc_i,
    input  wire logic       wb_stb_i,
    input  wire logic       wb_we_i,
    input  wire logic [2:0] wb_adr_i,
    input  wire logic [7:0] wb_dat_i,
    input  wire logic [3:0] wb_sel_i,
    output logic      [7:0] wb_dat_o,
    output logic            wb_ack_o,
    input  wire logic [1:0] sleepMode,
    input  wire logic       coreResult,
    output logic            coreEnable,
    output logic            coreLowPower,
    output logic      [1:0] coreHysteresis,
    output logic            corePosSelect,
    output logic      [1:0] coreNegSelect,
    output logic            padOut,
    output logic            padOutEn,
    output logic            eventOut,
    output logic            irqOut
);
    typedef struct packed {
        acc_pkg::acc_bus_state_t bus;
        logic [7:0]              ctrl;
        logic [7:0]              mux;
        logic [7:0]              inten;
        logic                    flag;
        logic [1:0]              sleepS1;
        logic [1:0]              sleepS2;
        logic [7:0]              rdata;
        logic                    coreEn;
        logic                    lowPwr;
        logic [1:0]              hys;
        logic                    posSel;
        logic [1:0]              negSel;
        logic                    pad;
        logic                    padEn;
        logic                    evt;
        logic                    irq;
    } acc_ctrl_state_t;

    acc_ctrl_state_t state_reg;
    acc_ctrl_state_t state_next;

    acc_sync_if syncLink ();

    acc_result_sync resultSync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .link     (syncLink)
    );

    // Edge match for the configured mode; reserved code raises nothing
    function automatic logic edgeHit(input logic [1:0] mode, input logic cur, input logic prev);
        logic hit;
        hit = 1'b0;
        case (mode)
            `ACC_EDGE_ANY:  hit = cur ^ prev;
            `ACC_EDGE_FALL: hit = prev & ~cur;
            `ACC_EDGE_RISE: hit = cur & ~prev;
            default:        hit = 1'b0;
        endcase
        return hit;
    endfunction

    // Read mux; unmapped and reserved bits return zero
    function automatic logic [7:0] readReg(input logic [2:0] adr, input acc_ctrl_state_t s,
                                           input logic stateBit);
        logic [7:0] d;
        d = 8'h00;
        case (adr)
            `ACC_OFF_CTRL:   d = s.ctrl;
            `ACC_OFF_MUX:    d = s.mux;
            `ACC_OFF_INTEN:  d = s.inten;
            `ACC_OFF_STATUS: begin
                d[`ACC_STAT_FLAG]  = s.flag;
                d[`ACC_STAT_STATE] = stateBit;
            end
            default:         d = 8'h00;
        endcase
        return d;
    endfunction

    logic             busReq;
    logic             wrStb;
    logic             clrFlag;
    logic             edgeEvt;
    logic             inStandby;
    logic             inPwrDown;
    logic             running;
    logic             result;

    // Inversion is applied once in the synchroniser so every consumer sees it
    assign syncLink.rawIn  = coreResult;
    assign syncLink.invert = state_reg.mux[`ACC_MUX_INVERT];
    assign result          = syncLink.syncOut;

    // Sleep mode comes from the power controller's domain, hence the double stage
    assign inStandby = (state_reg.sleepS2 == acc_pkg::ACC_SLEEP_STANDBY);
    assign inPwrDown = (state_reg.sleepS2 == acc_pkg::ACC_SLEEP_PWRDOWN);

    // Core keeps running in standby only if asked; never in power-down
    assign running = state_reg.ctrl[`ACC_CTRL_ENABLE] && !inPwrDown
                     && (!inStandby || state_reg.ctrl[`ACC_CTRL_RUNSTBY]);

    assign busReq  = wb_cyc_i && wb_stb_i && (state_reg.bus == acc_pkg::ACC_BUS_IDLE);
    assign wrStb   = busReq && wb_we_i && wb_sel_i[0];
    assign clrFlag = wrStb && (wb_adr_i == `ACC_OFF_STATUS) && wb_dat_i[`ACC_STAT_FLAG];
    // Flags frozen in standby even when the core runs there
    assign edgeEvt = running && !inStandby
                     && edgeHit(state_reg.ctrl[`ACC_CTRL_EDGE_LSB +: 2],
                                result, syncLink.prevOut);

    // Next-state logic for bus, registers and outputs
    always_comb begin
        state_next         = state_reg;
        state_next.sleepS1 = sleepMode;
        state_next.sleepS2 = state_reg.sleepS1;

        // Single-cycle ack, then one idle cycle so a held strobe is not taken twice
        case (state_reg.bus)
            acc_pkg::ACC_BUS_IDLE: begin
                if (busReq) begin
                    state_next.bus   = acc_pkg::ACC_BUS_ACK;
                    state_next.rdata = readReg(wb_adr_i, state_reg, result);
                end
            end
            acc_pkg::ACC_BUS_ACK: begin
                state_next.bus = acc_pkg::ACC_BUS_IDLE;
            end
            default: begin
                state_next.bus = acc_pkg::ACC_BUS_IDLE;
            end
        endcase

        // Register writes; unimplemented bits masked away
        if (wrStb) begin
            case (wb_adr_i)
                `ACC_OFF_CTRL:  state_next.ctrl  = wb_dat_i & `ACC_CTRL_MASK;
                `ACC_OFF_MUX:   state_next.mux   = wb_dat_i & `ACC_MUX_MASK;
                `ACC_OFF_INTEN: state_next.inten = wb_dat_i & `ACC_INTEN_MASK;
                default:        state_next.ctrl  = state_reg.ctrl;
            endcase
        end

        // Set wins over a simultaneous write-one clear
        if (edgeEvt) begin
            state_next.flag = 1'b1;
        end else if (clrFlag) begin
            state_next.flag = 1'b0;
        end

        // Core controls follow the register fields
        state_next.coreEn = running;
        state_next.lowPwr = state_reg.ctrl[`ACC_CTRL_LOWPWR];
        state_next.hys    = state_reg.ctrl[`ACC_CTRL_HYS_LSB +: 2];
        state_next.posSel = state_reg.mux[`ACC_MUX_POS_BIT];
        state_next.negSel = state_reg.mux[`ACC_MUX_NEG_LSB +: 2];

        // Pad and event only carry a result while the core runs
        state_next.padEn = running && state_reg.ctrl[`ACC_CTRL_PADEN];
        state_next.pad   = state_next.padEn && result;
        state_next.evt   = running && result;
        state_next.irq   = state_next.flag && state_reg.inten[`ACC_INTEN_IRQ];
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_reg      <= '0;
            state_reg.ctrl <= `ACC_RESET_VAL;
            state_reg.mux  <= `ACC_RESET_VAL;
        end else begin
            state_reg <= state_next;
        end
    end

    // All outputs come straight from the state register
    assign wb_dat_o       = state_reg.rdata;
    assign wb_ack_o       = (state_reg.bus == acc_pkg::ACC_BUS_ACK);
    assign coreEnable     = state_reg.coreEn;
    assign coreLowPower   = state_reg.lowPwr;
    assign coreHysteresis = state_reg.hys;
    assign corePosSelect  = state_reg.posSel;
    assign coreNegSelect  = state_reg.negSel;
    assign padOut         = state_reg.pad;
    assign padOutEn       = state_reg.padEn;
    assign eventOut       = state_reg.evt;
    assign irqOut         = state_reg.irq;
endmodule

/* File: hw/acc_regs.svh */
// Register offsets, field positions, reset values and timing counts of the comparator control
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH
`define ACC_OFF_CTRL      3'h0
`define ACC_OFF_MUX       3'h2
`define ACC_OFF_INTEN     3'h6
`define ACC_OFF_STATUS    3'h7
`define ACC_CTRL_ENABLE   0
`define ACC_CTRL_HYS_LSB  1
`define ACC_CTRL_LOWPWR   3
`define ACC_CTRL_EDGE_LSB 4
`define ACC_CTRL_PADEN    6
`define ACC_CTRL_RUNSTBY  7
`define ACC_MUX_NEG_LSB   0
`define ACC_MUX_POS_BIT   3
`define ACC_MUX_INVERT    7
`define ACC_INTEN_IRQ     0
`define ACC_STAT_FLAG     0
`define ACC_STAT_STATE    4
`define ACC_CTRL_MASK     8'hFF
`define ACC_MUX_MASK      8'h83
`define ACC_INTEN_MASK    8'h01
`define ACC_RESET_VAL     8'h00
`define ACC_EDGE_ANY      2'h0
`define ACC_EDGE_FALL     2'h2
`define ACC_EDGE_RISE     2'h3
`define ACC_SYNC_STAGES   3
`endif

/* File: hw/acc_pkg.sv */
// Types shared by the comparator control modules
package acc_pkg;
    typedef enum logic [1:0] {
        ACC_SLEEP_ACTIVE,
        ACC_SLEEP_IDLE,
        ACC_SLEEP_STANDBY,
        ACC_SLEEP_PWRDOWN
    } acc_sleep_t;
    typedef enum logic [1:0] {
        ACC_BUS_IDLE,
        ACC_BUS_ACK
    } acc_bus_state_t;
endpackage

/* File: hw/acc_sync_if.sv */
// Carrier between the control top and its result synchroniser
interface acc_sync_if;
    logic rawIn;
    logic invert;
    logic syncOut;
    logic prevOut;
    modport ctrl (output rawIn, output invert, input syncOut, input prevOut);
    modport sync (input rawIn, input invert, output syncOut, output prevOut);
endinterface

/* File: hw/acc_result_sync.sv */
// Three-stage synchroniser for the comparator result, with inversion and edge history
module acc_result_sync (
    input wire logic core_clk,
    input wire logic rst_n,
    acc_sync_if.sync link
);
    typedef struct packed {
        logic stage1;
        logic stage2;
        logic stage3;
        logic prev;
    } acc_sync_state_t;

    acc_sync_state_t state_reg;
    acc_sync_state_t state_next;

    // Stage1 feeds only stage2; inversion applied after the metastable stages
    always_comb begin
        state_next        = state_reg;
        state_next.stage1 = link.rawIn;
        state_next.stage2 = state_reg.stage1;
        state_next.stage3 = state_reg.stage2 ^ link.invert;
        state_next.prev   = state_reg.stage3;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign link.syncOut = state_reg.stage3;
    assign link.prevOut = state_reg.prev;
endmodule

/* File: sim/acc_core_model.sv */
// Behavioural model of the analog comparator core
module acc_core_model (
    input  wire logic core_clk,
    input  wire logic coreEnable,
    input  wire logic level,
    output logic      coreResult
);
    timeunit 1ns;
    timeprecision 1ps;
    // A core that is off holds its output low, so the state bit reads zero then while the mux invert bit is clear
    assign coreResult = coreEnable && level;
endmodule

/* File: sim/acc_ctrl_properties.sv */
// Port-level checks of the comparator control bank
module acc_ctrl_checker (
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_we_i,
    input wire logic [2:0] wb_adr_i,
    input wire logic [7:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [7:0] wb_dat_o,
    input wire logic       wb_ack_o,
    input wire logic [1:0] sleepMode,
    input wire logic       coreEnable,
    input wire logic       coreLowPower,
    input wire logic [1:0] coreHysteresis,
    input wire logic       corePosSelect,
    input wire logic [1:0] coreNegSelect,
    input wire logic       padOutEn,
    input wire logic       eventOut,
    input wire logic       irqOut
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    logic take;
    logic wrOk;
    // Request taken only while the slave is idle
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wrOk = take && wb_we_i && wb_sel_i[0];
    property p_ack; take |=> wb_ack_o ##1 !wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("bus answer not one cycle");
    property p_zero;
        take && !wb_we_i && wb_adr_i inside {1, 3, 4, 5} |=> wb_dat_o == 8'h00;
    endproperty
    a_zero: assert property (p_zero) else $error("unmapped read not zero");
    property p_lp; wrOk && wb_adr_i == 3'h0 |-> ##2 coreLowPower == $past(wb_dat_i[3], 2); endproperty
    a_lp: assert property (p_lp) else $error("low power not applied");
    property p_hys;
        wrOk && wb_adr_i == 3'h0 |-> ##2 coreHysteresis == $past(wb_dat_i[2:1], 2);
    endproperty
    a_hys: assert property (p_hys) else $error("hysteresis not applied");
    property p_mux;
        wrOk && wb_adr_i == 3'h2
        |-> ##2 coreNegSelect == $past(wb_dat_i[1:0], 2) && !corePosSelect;
    endproperty
    a_mux: assert property (p_mux) else $error("input select wrong");
    property p_pd; (sleepMode == 2'h3) [*4] |-> !coreEnable && !padOutEn; endproperty
    a_pd: assert property (p_pd) else $error("core alive in power-down");
    property p_ev; $rose(eventOut) |-> coreEnable; endproperty
    a_ev: assert property (p_ev) else $error("event while core off");
    // A flag clear drops the request one edge after it is taken, an enable write two
    property p_irq;
        $fell(irqOut) |-> $past(wrOk && wb_adr_i == 3'h7)
                          || $past(wrOk && wb_adr_i == 3'h6, 2);
    endproperty
    a_irq: assert property (p_irq) else $error("request dropped without clear");
endmodule
bind acc_ctrl_top acc_ctrl_checker u_chk (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sleepMode(sleepMode),
    .coreEnable(coreEnable), .coreLowPower(coreLowPower), .coreHysteresis(coreHysteresis),
    .corePosSelect(corePosSelect), .coreNegSelect(coreNegSelect), .padOutEn(padOutEn),
    .eventOut(eventOut), .irqOut(irqOut));

/* File: sim/analog_comparator_control_test.sv */
// Self-checking bench for the comparator control bank
module analog_comparator_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic       core_clk, rst_n, cyc, stb, we, level, ack, res, en, lp, pos, pad, padEn, ev, irq;
    logic [2:0] adr;
    logic [3:0] sel;
    logic [7:0] wdat, rdat, dout;
    logic [1:0] sleepMode, hys, neg;
    int         errCount = 0;
    int         checksDone = 0;
    logic [2:0] rowAdr [8] = '{3'h0, 3'h2, 3'h6, 3'h1, 3'h3, 3'h4, 3'h5, 3'h0};
    logic [7:0] rowExp [8] = '{8'hFF, 8'h83, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h5A};
    logic [1:0] mode [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
    logic [3:0] expRise = 4'h5;
    logic [3:0] expFall = 4'h3;
    acc_ctrl_top DUT (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(dout),
        .wb_ack_o(ack), .sleepMode(sleepMode), .coreResult(res), .coreEnable(en),
        .coreLowPower(lp), .coreHysteresis(hys), .corePosSelect(pos), .coreNegSelect(neg),
        .padOut(pad), .padOutEn(padEn), .eventOut(ev), .irqOut(irq));
    acc_core_model core (.core_clk(core_clk), .coreEnable(en), .level(level), .coreResult(res));
    // Clock of 50 ns
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = !core_clk;
    end
    task automatic endOfTest;
        $display("checks %0d errors %0d", checksDone, errCount);
        if (errCount == 0 && checksDone > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checksDone++;
        if (got !== exp) begin
            errCount++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One classic cycle; the request stays put until ack is seen at an edge
    task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d, input logic [3:0] s);
        int n;
        n = 0;
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= s;
        @(posedge core_clk);
        while (ack !== 1'b1 && n < 50) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 50) errCount++;
        rdat = dout;
        cyc <= 1'b0; stb <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'hF);
    endtask
    task automatic rdChk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
        bus(1'b0, a, 8'h00, 4'hF);
        check(rdat & m, e);
    endtask
    task automatic waitc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // A hang ends the run after 4000 cycles, more than ten times the expected span
    initial begin
        waitc(4000);
        errCount++;
        endOfTest();
    end
    initial begin
        rst_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 3'h0; wdat = 8'h00; sel = 4'hF;
        sleepMode = 2'h0; level = 1'b0;
        waitc(3);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            wr(rowAdr[i], i == 7 ? 8'h5A : 8'hFF);
            rdChk(rowAdr[i], 8'hFF, rowExp[i]);
        end
        check({2'h0, lp, hys, pos, neg}, 8'h2B);
        rst_n <= 1'b0;
        waitc(3);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) rdChk(i[2:0], 8'hFF, 8'h00);
        bus(1'b1, 3'h0, 8'hFF, 4'h0);
        rdChk(3'h0, 8'hFF, 8'h00);
        wr(3'h6, 8'h01);
        // Every edge mode against a rising and a falling result
        for (int i = 0; i < 4; i++) begin
            level <= 1'b0;
            wr(3'h0, {2'h0, mode[i], 4'h1});
            waitc(6);
            wr(3'h7, 8'h01);
            level <= 1'b1;
            waitc(8);
            check({7'h0, irq}, {7'h0, expRise[i]});
            rdChk(3'h7, 8'h01, {7'h0, expRise[i]});
            wr(3'h7, 8'h01);
            level <= 1'b0;
            waitc(8);
            rdChk(3'h7, 8'h01, {7'h0, expFall[i]});
        end
        // Result latency: low result reaches the event line on the fourth edge
        level <= 1'b1;
        waitc(8);
        level <= 1'b0;
        waitc(3);
        #1 check({7'h0, ev}, 8'h01);
        @(posedge core_clk);
        #1 check({7'h0, ev}, 8'h00);
        @(posedge core_clk);
        wr(3'h0, 8'h41);
        wr(3'h2, 8'h80);
        waitc(6);
        check({6'h0, padEn, pad}, 8'h03);
        rdChk(3'h7, 8'h10, 8'h10);
        wr(3'h0, 8'hC1);
        wr(3'h2, 8'h00);
        wr(3'h7, 8'h01);
        sleepMode <= 2'h2;
        waitc(5);
        check({7'h0, en}, 8'h01);
        level <= 1'b1;
        waitc(8);
        rdChk(3'h7, 8'h01, 8'h00);
        sleepMode <= 2'h3;
        waitc(5);
        check({6'h0, en, padEn}, 8'h00);
        wr(3'h0, 8'h01);
        sleepMode <= 2'h2;
        waitc(5);
        check({7'h0, en}, 8'h00);
        sleepMode <= 2'h0;
        waitc(5);
        level <= 1'b0;
        waitc(8);
        wr(3'h7, 8'h00);
        rdChk(3'h7, 8'h01, 8'h01);
        wr(3'h6, 8'h00);
        check({7'h0, irq}, 8'h00);
        wr(3'h6, 8'h01);
        check({7'h0, irq}, 8'h01);
        wr(3'h7, 8'h01);
        check({7'h0, irq}, 8'h00);
        endOfTest();
    end
endmodule
